// [temp_sensor_config_alert_ctrl.sv]
// Purpose: Configuration, conversion scheduling and alert logic of a temperature sensor.
// Assumes: Registers reached over Avalon-MM; the analog result arrives asynchronously.
// Notes: The conversion itself is modelled as a timed capture of the analog code.
// Operation
// - One 16-bit configuration register holds rate, sleep, mode, level, faults, one-shot.
// - Serial transfers send the configuration upper byte before the lower byte.
// - Bits 0-4 and 13 read zero, bit 14 reads one; all read-only.
// - With level select 0 the flag reads 1, then 0 after enough upper faults.
// - An active flag holds until enough consecutive lower-limit faults, then clears.
// - Level select inverts which flag value means active.
// - In comparator mode the flag always equals the alert pin.
// - Rate field 7:6 picks 4 s, 1 s, 250 ms or 125 ms; reset 10.
// - Temperature result changes only when a conversion completes.
// - A conversion starts right after power-on; result after one conversion time.
// - Continuous mode idles in standby until the period ends, then converts again.
// - Writing sleep select 1 stops conversions at once.
// - Entering sleep completes within 120 ms.
// - Registers stay readable and writable during sleep.
// - Writing sleep select 0 resumes continuous conversion at the set rate.
// - Latch select 0 gives comparator alert, 1 gives latched interrupt alert.
// - Comparator alert goes active at or above upper limit, stays until at or below lower.
// - Interrupt alert goes active when the upper limit, then the lower limit, is crossed in turn.
// - Level select 0 makes the alert pin active low, 1 active high.
// - Fault count codes 00 to 11 need one to four consecutive faults.
// - One-shot written 1 in sleep converts once, reads 1 meanwhile, then clears.
// - Interrupt alert clears on any register read or on setting sleep.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_config_alert_ctrl #(
	parameter int unsigned CONV_CYCLES = temp_cfg_pkg::CONV_CYCLES,
	parameter int unsigned P4S_CYCLES = temp_cfg_pkg::P4S_CYCLES,
	parameter int unsigned P1S_CYCLES = temp_cfg_pkg::P1S_CYCLES,
	parameter int unsigned P250_CYCLES = temp_cfg_pkg::P250_CYCLES,
	parameter int unsigned P125_CYCLES = temp_cfg_pkg::P125_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [temp_cfg_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Analog front end
	input wire logic [temp_cfg_pkg::TEMP_W-1:0] adc_code,
	output logic conv_active,
	// Alert pin
	output logic alert_pin
);
	import temp_cfg_pkg::*;

	// ****************************************
	// Parameter checks
	// ****************************************
	if (CONV_CYCLES < 2 || P125_CYCLES <= CONV_CYCLES || P4S_CYCLES >= (1 << CNT_W))
	begin : g_bad_timing
		$error("conversion timing parameters out of range");
	end

	localparam logic [CNT_W-1:0] CONV_M1 = CNT_W'(CONV_CYCLES - 1);

	typedef struct packed {
		conv_state_e st;
		logic [CNT_W-1:0] cnt;
		logic [1:0] rate;
		logic sleep;
		logic latch;
		logic level;
		logic [1:0] fsel;
		logic oneshot;
		logic [TEMP_W-1:0] lower;
		logic [TEMP_W-1:0] upper;
		logic [TEMP_W-1:0] temp;
		logic cmp_act;
		logic irq_act;
		logic irq_arm_low;
		logic al_flag;
		logic alert_pin;
		logic conv_act;
		logic done;
		logic eval;
		logic wait_r;
		logic [15:0] rdata;
	} ctrl_s;

	ctrl_s s_reg, s_next;

	logic [TEMP_W-1:0] adc_sync;
	logic hi_hit;
	logic lo_hit;
	logic [2:0] need;
	logic [IDX_W-1:0] idx;
	logic req;
	logic commit;
	logic wr_cfg;
	logic [15:0] cfg_word;
	logic [15:0] rd_mux;
	logic [CNT_W-1:0] period_m1;

	// ****************************************
	// Helpers
	// ****************************************
	sync2 #(.W(TEMP_W)) u_adc_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(adc_code),
		.q(adc_sync)
	);

	assign need = {1'b0, s_reg.fsel} + 3'h1;

	fault_counter u_hi_faults (
		.clk(clk),
		.sys_rst(sys_rst),
		.sample(s_reg.done),
		.fault($signed(s_reg.temp) >= $signed(s_reg.upper)),
		.need(need),
		.hit(hi_hit)
	);

	fault_counter u_lo_faults (
		.clk(clk),
		.sys_rst(sys_rst),
		.sample(s_reg.done),
		.fault($signed(s_reg.temp) <= $signed(s_reg.lower)),
		.need(need),
		.hit(lo_hit)
	);

	// ****************************************
	// Register decode
	// ****************************************
	assign idx = avs_address[ADDR_W-1:2];
	assign req = avs_read || avs_write;
	assign commit = req && !s_reg.wait_r;
	assign wr_cfg = commit && avs_write && idx == IDX_CFG;

	assign cfg_word = {s_reg.oneshot, CFG_RO_14_13, s_reg.fsel, s_reg.level, s_reg.latch,
		s_reg.sleep, s_reg.rate, s_reg.al_flag, CFG_LOW_RO};

	always_comb begin
		case (idx)
			IDX_TEMP: rd_mux = {s_reg.temp, 4'h0};
			IDX_CFG: rd_mux = cfg_word;
			IDX_LOWER: rd_mux = {s_reg.lower, 4'h0};
			IDX_UPPER: rd_mux = {s_reg.upper, 4'h0};
			default: rd_mux = 16'h0000;
		endcase
	end

	always_comb begin
		case (s_reg.rate)
			2'h0: period_m1 = CNT_W'(P4S_CYCLES - 1);
			2'h1: period_m1 = CNT_W'(P1S_CYCLES - 1);
			2'h2: period_m1 = CNT_W'(P250_CYCLES - 1);
			default: period_m1 = CNT_W'(P125_CYCLES - 1);
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.eval = s_reg.done;
		s_next.cnt = s_reg.cnt + 1'b1;
		// One wait cycle per access, so read data is registered before release.
		s_next.wait_r = !(req && s_reg.wait_r);
		if (req && s_reg.wait_r) begin
			s_next.rdata = rd_mux;
		end

		if (commit && avs_write) begin
			case (idx)
				IDX_CFG: begin
					if (avs_byteenable[1]) begin
						s_next.sleep = avs_writedata[BIT_SLEEP];
						s_next.latch = avs_writedata[BIT_LATCH];
						s_next.level = avs_writedata[BIT_LEVEL];
						s_next.fsel = avs_writedata[BIT_FAULT_HI:BIT_FAULT_LO];
					end
					if (avs_byteenable[0]) begin
						s_next.rate = avs_writedata[BIT_RATE_HI:BIT_RATE_LO];
					end
				end
				IDX_LOWER: begin
					if (avs_byteenable[1]) begin
						s_next.lower[11:4] = avs_writedata[15:8];
					end
					if (avs_byteenable[0]) begin
						s_next.lower[3:0] = avs_writedata[7:LIMIT_LSB];
					end
				end
				IDX_UPPER: begin
					if (avs_byteenable[1]) begin
						s_next.upper[11:4] = avs_writedata[15:8];
					end
					if (avs_byteenable[0]) begin
						s_next.upper[3:0] = avs_writedata[7:LIMIT_LSB];
					end
				end
				default: begin
				end
			endcase
		end

		// Conversion sequencing.
		case (s_reg.st)
			ST_CONV, ST_ONESHOT: begin
				if (s_reg.cnt >= CONV_M1) begin
					s_next.temp = adc_sync;
					s_next.done = 1'b1;
					// One-shot clears on return to sleep.
					s_next.oneshot = 1'b0;
					s_next.st = s_next.sleep ? ST_SLEEP : ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (s_reg.cnt >= period_m1) begin
					s_next.st = ST_CONV;
					s_next.cnt = '0;
				end
			end
			ST_SLEEP: begin
				if (!s_next.sleep) begin
					s_next.st = ST_CONV;
					s_next.cnt = '0;
				end
			end
			default: s_next.st = ST_CONV;
		endcase

		if (wr_cfg && avs_byteenable[1] && avs_writedata[BIT_SLEEP] && s_reg.st != ST_ONESHOT) begin
			if (avs_writedata[BIT_ONESHOT]) begin
				s_next.st = ST_ONESHOT;
				s_next.oneshot = 1'b1;
				s_next.cnt = '0;
			end else if (s_reg.st != ST_SLEEP) begin
				s_next.st = ST_SLEEP;
			end
		end

		// Clear on read or sleep set.
		if ((commit && avs_read) || (wr_cfg && avs_byteenable[1] && avs_writedata[BIT_SLEEP])) begin
			s_next.irq_act = 1'b0;
		end

		if (s_reg.eval) begin
			if (!s_reg.cmp_act && hi_hit) begin
				s_next.cmp_act = 1'b1;
			end else if (s_reg.cmp_act && lo_hit) begin
				s_next.cmp_act = 1'b0;
			end
			// Alternate limit crossings; a new event beats a same-cycle clear.
			if (!s_reg.irq_act && !s_reg.irq_arm_low && hi_hit) begin
				s_next.irq_act = 1'b1;
				s_next.irq_arm_low = 1'b1;
			end else if (!s_reg.irq_act && s_reg.irq_arm_low && lo_hit) begin
				s_next.irq_act = 1'b1;
				s_next.irq_arm_low = 1'b0;
			end
		end

		// Leaving interrupt mode restarts its sequence from the upper limit.
		if (!s_next.latch) begin
			s_next.irq_act = 1'b0;
			s_next.irq_arm_low = 1'b0;
		end

		// Level select sets the active value.
		s_next.al_flag = s_next.cmp_act ? s_next.level : !s_next.level;
		s_next.alert_pin = (s_next.latch ? s_next.irq_act : s_next.cmp_act) ? s_next.level : !s_next.level;
		s_next.conv_act = (s_next.st == ST_CONV) || (s_next.st == ST_ONESHOT);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_reg <= '0;
			s_reg.st <= ST_CONV;
			s_reg.rate <= RATE_RST;
			s_reg.lower <= LOWER_RST;
			s_reg.upper <= UPPER_RST;
			s_reg.al_flag <= 1'b1;
			s_reg.alert_pin <= 1'b1;
			s_reg.conv_act <= 1'b1;
			s_reg.wait_r <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign avs_readdata = {16'h0000, s_reg.rdata};
	assign avs_waitrequest = s_reg.wait_r;
	assign conv_active = s_reg.conv_act;
	assign alert_pin = s_reg.alert_pin;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence q_cfg_read;
		commit && avs_read && idx == IDX_CFG;
	endsequence

	sequence q_sleep_wr;
		wr_cfg && avs_byteenable[1] && avs_writedata[BIT_SLEEP] && !avs_writedata[BIT_ONESHOT];
	endsequence

	a_reserved_bits: assert property (q_cfg_read |-> avs_readdata[4:0] == 5'h00
		&& avs_readdata[14:13] == 2'h2)
		else $error("reserved configuration bits read wrong");
	a_flag_pin_match: assert property (!s_reg.latch |-> s_reg.al_flag == s_reg.alert_pin)
		else $error("flag differs from pin in comparator mode");
	a_flag_sense: assert property ($rose(s_reg.cmp_act) |-> s_reg.al_flag == s_reg.level)
		else $error("flag active value ignores level select");
	a_cmp_rise: assert property (s_reg.eval && !s_reg.latch && !s_reg.cmp_act && hi_hit
		|=> s_reg.cmp_act ##0 alert_pin == s_reg.level)
		else $error("comparator alert did not rise");
	a_cmp_hold: assert property (s_reg.cmp_act && !(s_reg.eval && lo_hit) |=> s_reg.cmp_act)
		else $error("comparator alert released early");
	a_sleep_stop: assert property (q_sleep_wr ##0 s_reg.st != ST_ONESHOT
		|=> s_reg.st == ST_SLEEP && !conv_active [*2])
		else $error("conversion not stopped by sleep");
	a_result_hold: assert property (!s_reg.done |-> s_reg.temp == $past(s_reg.temp))
		else $error("result changed outside conversion end");
	a_irq_clear: assert property (s_reg.latch && commit && avs_read && !s_reg.eval
		|=> !s_reg.irq_act)
		else $error("interrupt alert not cleared by read");
	a_oneshot_flag: assert property (s_reg.st == ST_ONESHOT |-> cfg_word[BIT_ONESHOT])
		else $error("one-shot bit low during conversion");
	a_standby_wait: assert property (s_reg.st == ST_STANDBY && s_reg.cnt < period_m1
		&& !wr_cfg |=> s_reg.st == ST_STANDBY)
		else $error("standby left before period end");
	a_bus_answer: assert property (req && s_reg.wait_r |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");
endmodule : temp_sensor_config_alert_ctrl
`default_nettype wire

// [temp_cfg_pkg.sv]
// Purpose: Shared constants for the temperature sensor configuration and alert block.
// Assumes: 40 MHz system clock; registers are 32-bit Avalon-MM words at four times their index.
// Notes: Times are kept in their printed unit; cycle counts derive from them.
`default_nettype none
package temp_cfg_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int unsigned CLK_KHZ = 40000;
	localparam int unsigned CONV_TIME_MS = 34;
	localparam int unsigned RATE_4S_MS = 4000;
	localparam int unsigned RATE_1S_MS = 1000;
	localparam int unsigned RATE_250MS_MS = 250;
	localparam int unsigned RATE_125MS_MS = 125;
	localparam int unsigned SLEEP_ENTRY_MAX_MS = 120;
	localparam int unsigned CONV_CYCLES = CONV_TIME_MS * CLK_KHZ;
	localparam int unsigned P4S_CYCLES = RATE_4S_MS * CLK_KHZ;
	localparam int unsigned P1S_CYCLES = RATE_1S_MS * CLK_KHZ;
	localparam int unsigned P250_CYCLES = RATE_250MS_MS * CLK_KHZ;
	localparam int unsigned P125_CYCLES = RATE_125MS_MS * CLK_KHZ;
	localparam int unsigned SLEEP_ENTRY_CYCLES = SLEEP_ENTRY_MAX_MS * CLK_KHZ;
	localparam int CNT_W = 28;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 6;
	localparam int IDX_W = 4;
	localparam int TEMP_W = 12;
	localparam logic [3:0] IDX_TEMP = 4'h0;
	localparam logic [3:0] IDX_CFG = 4'h1;
	localparam logic [3:0] IDX_LOWER = 4'h2;
	localparam logic [3:0] IDX_UPPER = 4'h3;

	// Configuration field positions.
	localparam int BIT_ALERT_FLAG = 5;
	localparam int BIT_RATE_LO = 6;
	localparam int BIT_RATE_HI = 7;
	localparam int BIT_SLEEP = 8;
	localparam int BIT_LATCH = 9;
	localparam int BIT_LEVEL = 10;
	localparam int BIT_FAULT_LO = 11;
	localparam int BIT_FAULT_HI = 12;
	localparam int BIT_ONESHOT = 15;
	localparam int LIMIT_LSB = 4;

	// Reset values and fixed read-only bits.
	localparam logic [1:0] RATE_RST = 2'h2;
	localparam logic [11:0] LOWER_RST = 12'h4b0;
	localparam logic [11:0] UPPER_RST = 12'h500;
	localparam logic [4:0] CFG_LOW_RO = 5'h00;
	localparam logic [1:0] CFG_RO_14_13 = 2'h2;

	typedef enum logic [1:0] {ST_CONV, ST_STANDBY, ST_SLEEP, ST_ONESHOT} conv_state_e;
endpackage : temp_cfg_pkg
`default_nettype wire

// [sync2.sv]
// Purpose: Two-flop synchroniser for a bus of asynchronous levels.
// Assumes: Bits are sampled independently; the source changes slowly.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int W = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} sync_s;

	sync_s s_reg, s_next;

	if (W < 1) begin : g_bad_w
		$error("sync2 width must be at least one");
	end

	always_comb begin
		s_next.meta = d;
		s_next.stab = s_reg.meta;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.stab;
endmodule : sync2
`default_nettype wire

// [fault_counter.sv]
// Purpose: Counts consecutive conversions that meet one limit condition.
// Assumes: sample pulses once per finished conversion.
// Notes: The count saturates at four, the largest selectable need.
`timescale 1ns/1ps
`default_nettype none
module fault_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Conversion events
	input wire logic sample,
	input wire logic fault,
	input wire logic [2:0] need,
	output logic hit
);
	typedef struct packed {
		logic [2:0] cnt;
	} fc_s;

	fc_s s_reg, s_next;

	always_comb begin
		s_next = s_reg;
		if (sample) begin
			if (!fault) begin
				s_next.cnt = 3'h0;
			end else if (s_reg.cnt != 3'h4) begin
				s_next.cnt = s_reg.cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hit = (s_reg.cnt >= need);
endmodule : fault_counter
`default_nettype wire

// [temp_source_model.sv]
// Purpose: Analog front end model that feeds the converter result to the block.
// Assumes: The result is a 12-bit two's complement code in 1/16 degree steps.
// Notes: The code moves on the falling edge, so it is unrelated to the sampling edge.
`timescale 1ns/1ps
`default_nettype none
module temp_source_model (
	// Clock
	input wire logic clk,
	// Temperature set by the bench
	input wire logic [11:0] target,
	// Code seen by the block
	output logic [11:0] adc_code
);
	// ****************************************
	// Source behaviour
	// ****************************************
	// The block must synchronise this code, so it changes away from its clock edge.
	always @(negedge clk) begin
		adc_code <= target;
	end
endmodule : temp_source_model
`default_nettype wire

// [temp_sensor_config_alert_ctrl_tb_top.sv]
// Purpose: Self-checking bench of the sensor configuration and alert block.
// Assumes: Shortened conversion and period counts; one wait cycle per bus access.
// Notes: Expected values are built from field positions and limit settings.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_config_alert_ctrl_tb_top;
	import temp_cfg_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	localparam int CONV = 20;
	int unsigned per[4] = '{200, 120, 80, 60};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [11:0] adc_set = 12'h080;
	logic [11:0] adc_code;
	logic conv_active;
	logic alert_pin;
	int miscompares = 0;
	int check_count = 0;
	int n;
	int hi;
	logic lv;
	logic [1:0] c;
	logic [31:0] d;

	temp_sensor_config_alert_ctrl #(.CONV_CYCLES(CONV), .P4S_CYCLES(200), .P1S_CYCLES(120),
		.P250_CYCLES(80), .P125_CYCLES(60)) i_temp_sensor_config_alert_ctrl (
		.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .adc_code(adc_code),
		.conv_active(conv_active), .alert_pin(alert_pin));
	temp_source_model i_temp_source_model (.clk(clk), .target(adc_set), .adc_code(adc_code));

	initial begin
		forever #12.5 clk = ~clk;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// The request is held until the edge at which waitrequest is seen low.
	task automatic bus_write(input logic [3:0] idx, input logic [31:0] wd, input logic [3:0] be);
		int w;
		w = 0;
		@(posedge clk);
		avs_address <= {idx, 2'h0};
		avs_writedata <= wd;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		do begin
			@(posedge clk);
			w++;
		end while (avs_waitrequest !== 1'b0 && w < 100);
		if (w >= 100) miscompares++;
		avs_write <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [3:0] idx, output logic [31:0] rd);
		int w;
		w = 0;
		@(posedge clk);
		avs_address <= {idx, 2'h0};
		avs_read <= 1'b1;
		do begin
			@(posedge clk);
			w++;
		end while (avs_waitrequest !== 1'b0 && w < 100);
		if (w >= 100) miscompares++;
		rd = avs_readdata;
		avs_read <= 1'b0;
	endtask : bus_read

	task automatic rd_chk(input string what, input logic [3:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		bus_read(idx, rd);
		check(what, exp, rd);
	endtask : rd_chk

	// Counts edges until conv_active takes the given level.
	task automatic wait_edge(input logic lvl, output int cnt);
		logic p;
		cnt = 0;
		p = conv_active;
		forever begin
			@(posedge clk);
			cnt++;
			if (conv_active === lvl && p !== lvl) break;
			p = conv_active;
			if (cnt > 2000) begin
				miscompares++;
				break;
			end
		end
	endtask : wait_edge

	task automatic wait_conv(input int k);
		int t;
		repeat (k) begin
			wait_edge(1'b0, t);
			repeat (6) @(posedge clk);
		end
	endtask : wait_conv

	task automatic pin_chk(input logic exp);
		check("alert_pin", {31'h0, exp}, {31'h0, alert_pin});
	endtask : pin_chk

	// ****************************************
	// Watchdog
	// ****************************************
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		print_verdict();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check("conv after reset", 32'h1, {31'h0, conv_active});
		pin_chk(1'b1);
		rd_chk("cfg reset", IDX_CFG, 32'h40a0);
		rd_chk("lower reset", IDX_LOWER, 32'h4b00);
		rd_chk("upper reset", IDX_UPPER, 32'h5000);
		rd_chk("temp before result", IDX_TEMP, 32'h0);
		wait_conv(1);
		rd_chk("first result", IDX_TEMP, 32'h0800);
		bus_write(IDX_TEMP, 32'hffff, 4'h3);
		rd_chk("temp read-only", IDX_TEMP, 32'h0800);
		bus_write(4'h5, 32'h1234, 4'h3);
		rd_chk("unmapped", 4'h5, 32'h0);
		// Bit 4 is left at zero; the other fixed bits are written against their value.
		bus_write(IDX_CFG, 32'h20ef, 4'h3);
		rd_chk("cfg read-only bits", IDX_CFG, 32'h40e0);
		bus_write(IDX_LOWER, 32'h00f0, 4'h1);
		rd_chk("lower low lane", IDX_LOWER, 32'h4bf0);
		bus_write(IDX_LOWER, 32'h3a00, 4'h2);
		rd_chk("lower high lane", IDX_LOWER, 32'h3af0);
		for (int r = 0; r < 4; r++) begin
			bus_write(IDX_CFG, 32'(r) << 6, 4'h3);
			wait_edge(1'b1, n);
			wait_edge(1'b1, n);
			check("period", per[r], 32'(n));
		end
		bus_write(IDX_CFG, 32'h0180, 4'h3);
		repeat (3) @(posedge clk);
		hi = 0;
		repeat (300) begin
			@(posedge clk);
			if (conv_active !== 1'b0) hi++;
		end
		check("sleep idle", 32'h0, 32'(hi));
		rd_chk("cfg asleep", IDX_CFG, 32'h41a0);
		adc_set <= 12'h0c0;
		bus_write(IDX_CFG, 32'h8180, 4'h3);
		repeat (3) @(posedge clk);
		check("one-shot runs", 32'h1, {31'h0, conv_active});
		rd_chk("one-shot bit set", IDX_CFG, 32'hc1a0);
		wait_edge(1'b0, n);
		repeat (6) @(posedge clk);
		rd_chk("one-shot bit clear", IDX_CFG, 32'h41a0);
		rd_chk("one-shot result", IDX_TEMP, 32'h0c00);
		adc_set <= 12'h0a0;
		repeat (60) @(posedge clk);
		rd_chk("result held", IDX_TEMP, 32'h0c00);
		bus_write(IDX_CFG, 32'h0080, 4'h3);
		wait_edge(1'b1, n);
		check("wake", 32'h1, {31'h0, n <= 3});
		bus_write(IDX_UPPER, 32'h2000, 4'h3);
		bus_write(IDX_LOWER, 32'h1000, 4'h3);
		rd_chk("upper written", IDX_UPPER, 32'h2000);
		adc_set <= 12'h080;
		wait_conv(2);
		for (int k = 0; k < 8; k++) begin
			lv = k[2];
			c = k[1:0];
			bus_write(IDX_CFG, 32'h00c0 | (32'(c) << 11) | (32'(lv) << 10), 4'h3);
			wait_conv(1);
			pin_chk(~lv);
			adc_set <= 12'h300;
			if (c != 2'h0) begin
				wait_conv(int'(c));
				pin_chk(~lv);
			end
			wait_conv(1);
			pin_chk(lv);
			d = 32'h40c0 | (32'(c) << 11) | (32'(lv) << 10) | (32'(lv) << 5);
			rd_chk("flag active", IDX_CFG, d);
			adc_set <= 12'h080;
			wait_conv(int'(c) + 1);
			pin_chk(~lv);
			rd_chk("flag inactive", IDX_CFG, d ^ 32'h20);
		end
		bus_write(IDX_CFG, 32'h02c0, 4'h3);
		wait_conv(1);
		adc_set <= 12'h300;
		wait_conv(1);
		pin_chk(1'b0);
		wait_conv(1);
		pin_chk(1'b0);
		bus_read(IDX_TEMP, d);
		repeat (3) @(posedge clk);
		pin_chk(1'b1);
		wait_conv(1);
		pin_chk(1'b1);
		adc_set <= 12'h080;
		wait_conv(1);
		pin_chk(1'b0);
		bus_write(IDX_CFG, 32'h03c0, 4'h3);
		repeat (3) @(posedge clk);
		pin_chk(1'b1);
		print_verdict();
	end
endmodule : temp_sensor_config_alert_ctrl_tb_top
`default_nettype wire
